// *** rtl/adchb_pkg.sv ***
// constants and types shared by both ends of the converter host port
package adchb_pkg;
	localparam int RES_W = 12;
	localparam int PADDR_W = 2;
	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	// port addresses decoded by the converter
	localparam logic [1:0] PORT_CONV = 2'h0;
	localparam logic [1:0] PORT_STAT = 2'h1;
	localparam logic [1:0] PORT_DATA = 2'h2;
	localparam logic [1:0] PORT_HBS = 2'h3;
	localparam int STATBIT_EOC = 0;
	// timing
	localparam int CLK_NS = 10;
	localparam int ACCESS_NS = 240;
	localparam int ACC_CYC = ACCESS_NS / CLK_NS;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] ACC_LAST = CNT_W'(ACC_CYC - 1);
	localparam int CONV_CYC_DEF = 100;
	// host register map
	localparam int AXI_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_MASK = 8'h0c;
	localparam logic [7:0] REG_RESULT = 8'h10;
	localparam logic [7:0] REG_STATE = 8'h14;
	localparam int CTRL_W = 4;
	localparam int CTRL_WIDE = 0;
	localparam int CTRL_RJUST = 1;
	localparam int CTRL_ASYNC = 2;
	localparam int CTRL_AUTO = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h3;
	localparam int CMD_START = 0;
	localparam int CMD_READ = 1;
	localparam int CMD_POLL = 2;
	localparam int EV_W = 3;
	localparam int EV_DONE = 0;
	localparam int EV_READY = 1;
	localparam int EV_OVR = 2;
	localparam int STATE_BUSY = 0;
	localparam int STATE_EOC = 1;
	localparam int STATE_DMA = 2;
	localparam int STATE_POLLED = 3;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum {H_IDLE, H_WR, H_PREP, H_RDHI, H_RDLO, H_RDW, H_RDST} adchb_hstate_type;
endpackage

// *** rtl/adchb_if.sv ***
// pin-level link between converter and host glue
`timescale 1ns/100ps
interface adchb_if;
	logic ce_n;
	logic cs_n;
	logic wr_n;
	logic oe_n;
	logic [1:0] addr;
	logic high_byte_select;
	logic width_select;
	logic justify_right;
	logic [11:0] result_bits;
	logic result_oe;
	logic eoc;
	logic eoc_oe;
	logic [11:0] result_bus;
	logic eoc_bus;
	// undriven three-state lines resolve low
	assign result_bus = result_oe ? result_bits : 12'h000;
	assign eoc_bus = eoc_oe & eoc;
	modport device(input ce_n, input cs_n, input wr_n, input oe_n, input addr,
		input high_byte_select, input width_select, input justify_right,
		output result_bits, output result_oe, output eoc, output eoc_oe);
	modport host(output ce_n, output cs_n, output wr_n, output oe_n, output addr,
		output high_byte_select, output width_select, output justify_right,
		input result_bus, input eoc_bus);
endinterface

// *** rtl/adchb_fmt.sv ***
// output formatter: width, justification and byte select of the result
`timescale 1ns/100ps
module adchb_fmt
	import adchb_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [RES_W-1:0] result,
	input wire logic eoc,
	input wire logic sel_status,
	input wire logic width_select,
	input wire logic justify_right,
	input wire logic high_byte_select,
	output logic [RES_W-1:0] data_r
);
	logic [RES_W-1:0] data_nxt;

	always_comb begin
		data_nxt = '0;
		if (sel_status) begin
			data_nxt[STATBIT_EOC] = eoc;
		end else if (width_select) begin
			data_nxt = result;
		end else if (justify_right) begin
			// right justified: 4 + 8
			if (high_byte_select) begin
				data_nxt[NIB_W-1:0] = result[RES_W-1:BYTE_W];
			end else begin
				data_nxt[BYTE_W-1:0] = result[BYTE_W-1:0];
			end
		end else begin
			if (high_byte_select) begin
				data_nxt[BYTE_W-1:0] = result[RES_W-1:NIB_W];
			end else begin
				data_nxt[BYTE_W-1:NIB_W] = result[NIB_W-1:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_r <= '0;
		end else begin
			data_r <= data_nxt;
		end
	end
endmodule // adchb_fmt

// *** rtl/adchb_device.sv ***
// converter end: conversion start, end-of-conversion flag and result port
`timescale 1ns/100ps
module adchb_device
	import adchb_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYC_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	adchb_if.device bus,
	input wire logic async_mode,
	input wire logic ext_trigger,
	input wire logic [RES_W-1:0] sample_in,
	output logic busy
);
	logic wr_act;
	logic wr_act_r;
	logic trig_r;
	logic start;
	logic busy_r;
	logic eoc_r;
	logic [15:0] conv_cnt_r;
	logic [RES_W-1:0] result_r;
	logic [RES_W-1:0] data_r;
	logic sel_status;

	// ==========================================
	// start sources
	assign wr_act = ~bus.cs_n & ~bus.wr_n & (bus.addr == PORT_CONV);
	// external trigger start
	// writes are ignored in async mode so the trigger alone sets the rate
	assign start = ~busy_r & (async_mode ? (ext_trigger & ~trig_r) : (wr_act & ~wr_act_r));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_act_r <= 1'b0;
			trig_r <= 1'b0;
		end else begin
			wr_act_r <= wr_act;
			trig_r <= ext_trigger;
		end
	end

	// ==========================================
	// conversion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_r <= 1'b0;
			conv_cnt_r <= '0;
		end else if (start) begin
			busy_r <= 1'b1;
			conv_cnt_r <= '0;
		end else if (busy_r) begin
			conv_cnt_r <= conv_cnt_r + 16'h0001;
			if (conv_cnt_r == 16'(CONV_CYC - 1)) begin
				busy_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eoc_r <= 1'b0;
			result_r <= '0;
		end else if (start) begin
			eoc_r <= 1'b0;
		end else if (busy_r && conv_cnt_r == 16'(CONV_CYC - 1)) begin
			eoc_r <= 1'b1;
			result_r <= sample_in;
		end
	end

	// ==========================================
	// read port
	// status and data at separate ports
	assign sel_status = (bus.addr == PORT_STAT);

	adchb_fmt u_fmt (
		.aclk(aclk),
		.aresetn(aresetn),
		.result(result_r),
		.eoc(eoc_r),
		.sel_status(sel_status),
		.width_select(bus.width_select),
		.justify_right(bus.justify_right),
		.high_byte_select(bus.high_byte_select),
		.data_r(data_r)
	);

	assign bus.result_oe = ~bus.ce_n & ~bus.cs_n & ~bus.oe_n;
	assign bus.result_bits = data_r;
	assign bus.eoc = eoc_r;
	assign bus.eoc_oe = ~bus.ce_n;
	assign busy = busy_r;
endmodule // adchb_device

// *** rtl/adchb_host.sv ***
// host end: glue logic sequencing converter cycles, with an AXI4-Lite register file
`timescale 1ns/100ps
// Summary of operation
// - converter flags each finished conversion
// - rising done flag raises interrupt, starts read
// - write to converter port starts conversion
// - status and result returned on reads
// - each access stretched by wait states
// - async mode starts on external trigger
// - done latches request, result read clears it
// - request served before next conversion ends
// - status and data at distinct ports
// - host drives byte selection line
// - justify input high gives right justification
// - high byte select set by prior write
// - select released at end of high byte read
// - output enable from chip enable, chip select and read strobe
// - each read lasts 240 ns
// - twelve parallel bits or two bytes
// - outputs three-stated when not enabled
module adchb_host
	import adchb_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	output logic dma_request_ch1,
	adchb_if.host bus
);
	adchb_hstate_type hstate_r;
	adchb_hstate_type hstate_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic last;
	logic [CTRL_W-1:0] ctrl_r;
	logic [EV_W-1:0] mask_r;
	logic [EV_W-1:0] stat_r;
	logic [EV_W-1:0] ev;
	logic [RES_W-1:0] result_r;
	logic [BYTE_W-1:0] hi_r;
	logic hbs_r;
	logic dma_r;
	logic eoc_prev_r;
	logic eoc_rise;
	logic polled_r;
	logic start_req_r;
	logic read_req_r;
	logic poll_req_r;
	logic wr_go;
	logic rd_go;
	logic [31:0] cmd;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic rd_hit;
	logic res_done;

	// ==========================================
	// AXI4-Lite slave: address and data taken together
	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign rd_go = s_axi_arvalid & ~rvalid_r;
	assign s_axi_arready = ~rvalid_r;
	assign cmd = (wr_go && s_axi_awaddr == REG_CMD && s_axi_wstrb[0]) ? s_axi_wdata : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= AXI_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= (s_axi_awaddr == REG_CTRL || s_axi_awaddr == REG_CMD ||
				s_axi_awaddr == REG_MASK) ? AXI_OKAY : AXI_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= CTRL_RST;
			mask_r <= '0;
		end else if (wr_go && s_axi_wstrb[0]) begin
			if (s_axi_awaddr == REG_CTRL) begin
				ctrl_r <= s_axi_wdata[CTRL_W-1:0];
			end
			if (s_axi_awaddr == REG_MASK) begin
				mask_r <= s_axi_wdata[EV_W-1:0];
			end
		end
	end

	always_comb begin
		rdata_nxt = 32'h0;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			REG_CTRL: rdata_nxt[CTRL_W-1:0] = ctrl_r;
			REG_STAT: rdata_nxt[EV_W-1:0] = stat_r;
			REG_MASK: rdata_nxt[EV_W-1:0] = mask_r;
			REG_RESULT: rdata_nxt[RES_W-1:0] = result_r;
			REG_STATE: begin
				rdata_nxt[STATE_BUSY] = (hstate_r != H_IDLE);
				rdata_nxt[STATE_EOC] = bus.eoc_bus;
				rdata_nxt[STATE_DMA] = dma_r;
				rdata_nxt[STATE_POLLED] = polled_r;
			end
			REG_CMD: rdata_nxt = 32'h0;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r <= AXI_OKAY;
			rdata_r <= 32'h0;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rresp_r <= rd_hit ? AXI_OKAY : AXI_SLVERR;
			rdata_r <= rdata_nxt;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// ==========================================
	// events, sticky status, interrupt
	assign eoc_rise = bus.eoc_bus & ~eoc_prev_r;
	assign res_done = last && (hstate_r == H_RDLO || hstate_r == H_RDW);
	assign ev[EV_DONE] = eoc_rise;
	assign ev[EV_READY] = res_done;
	// new result while previous still unread
	assign ev[EV_OVR] = eoc_rise & (dma_r | (hstate_r == H_PREP) |
		(hstate_r == H_RDHI) | (hstate_r == H_RDLO) | (hstate_r == H_RDW));

	// a read clears, a same-cycle event still sets
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_r <= '0;
			eoc_prev_r <= 1'b0;
		end else begin
			stat_r <= ((rd_go && s_axi_araddr == REG_STAT) ? '0 : stat_r) | ev;
			eoc_prev_r <= bus.eoc_bus;
		end
	end

	assign irq = |(stat_r & mask_r);

	// request latch cleared by result read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dma_r <= 1'b0;
		end else begin
			dma_r <= (dma_r & ~res_done) | eoc_rise;
		end
	end
	assign dma_request_ch1 = dma_r;

	// ==========================================
	// request latches
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_req_r <= 1'b0;
			read_req_r <= 1'b0;
			poll_req_r <= 1'b0;
		end else begin
			start_req_r <= (start_req_r & (hstate_r != H_IDLE)) | cmd[CMD_START];
			read_req_r <= (read_req_r & ~(hstate_r == H_IDLE && hstate_nxt != H_IDLE &&
				hstate_nxt != H_WR && hstate_nxt != H_RDST)) | cmd[CMD_READ] |
				(eoc_rise & ctrl_r[CTRL_AUTO]);
			poll_req_r <= (poll_req_r & (hstate_nxt != H_RDST)) | cmd[CMD_POLL];
		end
	end

	// ==========================================
	// cycle sequencer
	// access held for the full 240 ns
	assign last = (cnt_r == ACC_LAST);

	always_comb begin
		hstate_nxt = hstate_r;
		case (hstate_r)
			H_IDLE: begin
				if (start_req_r) begin
					hstate_nxt = H_WR;
				end else if (read_req_r) begin
					hstate_nxt = ctrl_r[CTRL_WIDE] ? H_RDW : H_PREP;
				end else if (poll_req_r) begin
					hstate_nxt = H_RDST;
				end
			end
			H_WR: hstate_nxt = last ? H_IDLE : H_WR;
			H_PREP: hstate_nxt = last ? H_RDHI : H_PREP;
			H_RDHI: hstate_nxt = last ? H_RDLO : H_RDHI;
			H_RDLO: hstate_nxt = last ? H_IDLE : H_RDLO;
			H_RDW: hstate_nxt = last ? H_IDLE : H_RDW;
			H_RDST: hstate_nxt = last ? H_IDLE : H_RDST;
			default: hstate_nxt = H_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hstate_r <= H_IDLE;
			cnt_r <= '0;
		end else begin
			hstate_r <= hstate_nxt;
			cnt_r <= (hstate_r == H_IDLE || last) ? '0 : cnt_r + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hbs_r <= 1'b0;
		end else if (hstate_r == H_PREP) begin
			hbs_r <= 1'b1;
		end else if (hstate_r == H_RDHI && last) begin
			hbs_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_r <= '0;
			result_r <= '0;
			polled_r <= 1'b0;
		end else if (last) begin
			case (hstate_r)
				H_RDHI: hi_r <= bus.result_bus[BYTE_W-1:0];
				H_RDLO: result_r <= ctrl_r[CTRL_RJUST] ?
					{hi_r[NIB_W-1:0], bus.result_bus[BYTE_W-1:0]} :
					{hi_r, bus.result_bus[BYTE_W-1:NIB_W]};
				H_RDW: result_r <= bus.result_bus;
				H_RDST: polled_r <= bus.result_bus[STATBIT_EOC];
				default: hi_r <= hi_r;
			endcase
		end
	end

	// ==========================================
	// pin drive
	// write cycle to conversion port
	// port decode picks status or data
	always_comb begin
		case (hstate_r)
			H_WR: bus.addr = PORT_CONV;
			H_PREP: bus.addr = PORT_HBS;
			H_RDST: bus.addr = PORT_STAT;
			default: bus.addr = PORT_DATA;
		endcase
	end
	assign bus.ce_n = 1'b0;
	assign bus.cs_n = (hstate_r == H_IDLE);
	assign bus.wr_n = ~(hstate_r == H_WR || hstate_r == H_PREP);
	assign bus.oe_n = ~(hstate_r == H_RDHI || hstate_r == H_RDLO ||
		hstate_r == H_RDW || hstate_r == H_RDST);
	assign bus.high_byte_select = hbs_r;
	assign bus.justify_right = ctrl_r[CTRL_RJUST];
	assign bus.width_select = ctrl_r[CTRL_WIDE];
endmodule // adchb_host

// *** sim/adchb_props.sv ***
// concurrent checks on the pin link between host glue and converter
`timescale 1ns/100ps
module adchb_props
	import adchb_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce_n,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic oe_n,
	input wire logic [1:0] addr,
	input wire logic high_byte_select,
	input wire logic result_oe,
	input wire logic eoc,
	input wire logic eoc_oe,
	input wire logic [11:0] result_bus
);
	// ==========================================
	// strobe length counters
	// a byte pair keeps the read strobe low for two accesses
	logic [5:0] rd_cnt_r;
	logic [5:0] wr_cnt_r;
	always_ff @(posedge aclk) begin
		if (!aresetn || oe_n) rd_cnt_r <= 6'h00;
		else rd_cnt_r <= rd_cnt_r + 6'h01;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || wr_n) wr_cnt_r <= 6'h00;
		else wr_cnt_r <= wr_cnt_r + 6'h01;
	end
	// ==========================================
	// properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
	property p_rd_len; $rose(oe_n) |-> (rd_cnt_r == 6'h18 || rd_cnt_r == 6'h30); endproperty
	a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");
	property p_wr_len; $rose(wr_n) |-> wr_cnt_r == 6'h18; endproperty
	a_oe: assert property (p_oe) else $error("data driver enable wrong");
	property p_oe; result_oe == (!ce_n && !cs_n && !oe_n); endproperty
	a_eoc_oe: assert property (p_eoc_oe) else $error("flag driver enable wrong");
	property p_eoc_oe; eoc_oe == !ce_n; endproperty
	a_idle: assert property (p_idle) else $error("strobe without select");
	property p_idle; cs_n |-> wr_n && oe_n; endproperty
	a_excl: assert property (p_excl) else $error("read and write together");
	property p_excl; !wr_n |-> oe_n; endproperty
	a_stat: assert property (p_stat) else $error("status word wrong");
	property p_stat;
		!oe_n && !cs_n && addr == PORT_STAT && !$past(oe_n) && $past(addr) == PORT_STAT
		|-> result_bus == {11'h000, $past(eoc)};
	endproperty
	a_hbs_set: assert property (p_hbs_set) else $error("byte select rose alone");
	property p_hbs_set; $rose(high_byte_select) |-> !$past(wr_n) && $past(addr) == PORT_HBS;
	endproperty
	a_hbs_hi: assert property (p_hbs_hi) else $error("high read without select");
	property p_hbs_hi;
		!oe_n && addr == PORT_DATA && $past(addr) == PORT_HBS |-> high_byte_select;
	endproperty
	a_hbs_rel: assert property (p_hbs_rel) else $error("byte select release wrong");
	property p_hbs_rel;
		$fell(high_byte_select) |-> !oe_n && addr == PORT_DATA && !$past(oe_n) ##1 !oe_n;
	endproperty
endmodule // adchb_props

// *** sim/adc_host_bus_readout_bench.sv ***
// self-checking bench: host glue and converter joined over the pin link
`timescale 1ns/100ps
module adc_host_bus_readout_bench
	import adchb_pkg::*;
;
	logic aclk;
	logic aresetn;
	logic [AXI_AW-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	logic irq, dma, async_mode, ext_trigger, busy;
	logic [RES_W-1:0] sample_in;
	int n_errors;
	int checks_done;
	logic [33:0] exp_rd[$];
	logic [1:0] exp_wr[$];
	adchb_if link();
	// short conversion keeps the run brief
	adchb_device #(.CONV_CYC(10)) u_adchb_device(.aclk(aclk), .aresetn(aresetn), .bus(link),
		.async_mode(async_mode), .ext_trigger(ext_trigger), .sample_in(sample_in), .busy(busy));
	adchb_host u_adchb_host(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
		.dma_request_ch1(dma), .bus(link));
	adchb_props u_props(.aclk(aclk), .aresetn(aresetn), .ce_n(link.ce_n), .cs_n(link.cs_n),
		.wr_n(link.wr_n), .oe_n(link.oe_n), .addr(link.addr),
		.high_byte_select(link.high_byte_select), .result_oe(link.result_oe),
		.eoc(link.eoc), .eoc_oe(link.eoc_oe), .result_bus(link.result_bus));
	// ==========================================
	// helpers
	task automatic chk(input string what, input logic [33:0] e, input logic [33:0] s);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic wrap_up();
		if (n_errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	function automatic logic seen(input int w);
		case (w)
			0: return awready & wready;
			1: return bvalid;
			2: return arready;
			3: return rvalid;
			4: return link.eoc_bus;
			default: return busy;
		endcase
	endfunction
	// every wait is bounded; running out ends the run
	task automatic till(input int w);
		for (int i = 0; i < 400; i++) begin
			@(posedge aclk);
			if (seen(w) === 1'b1) return;
		end
		n_errors++;
		wrap_up();
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_wr.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		till(0);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		till(1);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_rd.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		till(2);
		arvalid <= 1'b0;
		till(3);
	endtask
	// waits for the start to be taken, then for the flag
	task automatic conv();
		till(5);
		chk("eoc", 34'h0, 34'(link.eoc_bus));
		till(4);
		chk("busy", 34'h0, 34'(busy));
		repeat (2) @(posedge aclk);
	endtask
	// ==========================================
	// response monitor
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready) begin
			chk("rdata", exp_rd.pop_front(), {rresp, rdata});
		end
		if (bvalid === 1'b1 && bready) begin
			chk("bresp", 34'(exp_wr.pop_front()), 34'(bresp));
		end
	end
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// ==========================================
	// main sequence
	initial begin
		logic [RES_W-1:0] smp;
		{aresetn, awvalid, wvalid, arvalid, async_mode, ext_trigger} = 6'h00;
		{awaddr, araddr, wdata, sample_in} = 60'h0;
		{wstrb, bready, rready} = 6'h3f;
		n_errors = 0;
		checks_done = 0;
		void'($urandom(32'h41a9));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(REG_CTRL, 32'h3, AXI_OKAY);
		axr(REG_STATE, 32'h0, AXI_OKAY);
		axr(8'h18, 32'h0, AXI_SLVERR);
		axw(8'h18, 32'h1, AXI_SLVERR);
		wstrb <= 4'h0;
		axw(REG_CTRL, 32'h0, AXI_OKAY);
		wstrb <= 4'hf;
		axr(REG_CTRL, 32'h3, AXI_OKAY);
		axr(REG_CMD, 32'h0, AXI_OKAY);
		// width and justification in all four settings
		for (int m = 0; m < 4; m++) begin
			smp = 12'($urandom());
			sample_in <= smp;
			axw(REG_CTRL, 32'(m), AXI_OKAY);
			axw(REG_MASK, 32'(m & 1), AXI_OKAY);
			axw(REG_CMD, 32'h1, AXI_OKAY);
			conv();
			chk("irq", 34'(m & 1), 34'(irq));
			chk("dma", 34'h1, 34'(dma));
			axr(REG_STAT, 32'h1, AXI_OKAY);
			axw(REG_CMD, 32'h2, AXI_OKAY);
			chk("irq", 34'h0, 34'(irq));
			repeat (100) @(posedge aclk);
			axr(REG_RESULT, 32'(smp), AXI_OKAY);
			axr(REG_STAT, 32'h2, AXI_OKAY);
			chk("dma", 34'h0, 34'(dma));
		end
		axw(REG_CMD, 32'h4, AXI_OKAY);
		repeat (40) @(posedge aclk);
		axr(REG_STATE, 32'ha, AXI_OKAY);
		// second result lands before the first was taken
		axw(REG_CMD, 32'h1, AXI_OKAY);
		conv();
		axw(REG_CMD, 32'h1, AXI_OKAY);
		conv();
		axr(REG_STAT, 32'h5, AXI_OKAY);
		axw(REG_CMD, 32'h2, AXI_OKAY);
		repeat (100) @(posedge aclk);
		chk("dma", 34'h0, 34'(dma));
		// trigger-driven conversion, read out automatically
		async_mode <= 1'b1;
		smp = 12'($urandom());
		sample_in <= smp;
		axw(REG_CTRL, 32'ha, AXI_OKAY);
		axw(REG_CMD, 32'h1, AXI_OKAY);
		repeat (60) @(posedge aclk);
		chk("eoc", 34'h1, 34'(link.eoc_bus));
		ext_trigger <= 1'b1;
		conv();
		ext_trigger <= 1'b0;
		repeat (100) @(posedge aclk);
		axr(REG_RESULT, 32'(smp), AXI_OKAY);
		axr(REG_STAT, 32'h3, AXI_OKAY);
		chk("dma", 34'h0, 34'(dma));
		// reset in mid-run, cutting a write access short
		axw(REG_MASK, 32'h7, AXI_OKAY);
		axw(REG_CMD, 32'h1, AXI_OKAY);
		repeat (5) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(REG_STATE, 32'h0, AXI_OKAY);
		axr(REG_MASK, 32'h0, AXI_OKAY);
		axr(REG_CTRL, 32'h3, AXI_OKAY);
		chk("irq", 34'h0, 34'(irq));
		wrap_up();
	end
endmodule // adc_host_bus_readout_bench
